/* File: design/bcl_pkg.sv */
/*
  Shared constants, types and the checksum step for the boot code RAM loader.
  Assumes a single 125 MHz clock domain and an 8-bit special function register bus.
*/
package bcl_pkg;
  // ==========================================
  // Register map and field positions
  localparam logic [7:0] BCL_MAP_CTRL_ADDR = 8'hd1;
  localparam int BCL_MAP_BIT_POS = 3;
  localparam logic BCL_MAP_BIT_RESET = 1'b0;
  localparam int BCL_BOOT_SEL_POS = 6;
  localparam int BCL_SSB_TWI_EN_POS = 7;
  localparam int BCL_SSB_UART_EN_POS = 6;
  // ==========================================
  // Address map of the loader and the image
  localparam logic [15:0] BCL_LOADER_BASE = 16'hc000;
  localparam logic [15:0] BCL_LOADER_ENTRY = 16'hf800;
  localparam logic [15:0] BCL_APP_ENTRY = 16'h0000;
  localparam logic [13:0] BCL_SSB_ADDR = 14'h3ffd;
  localparam logic [13:0] BCL_LAST_ADDR = 14'h3fff;
  // ==========================================
  // Checksum constants
  localparam logic [15:0] BCL_CRC_INIT = 16'hffff;
  localparam logic [15:0] BCL_CRC_POLY = 16'h8408;
  localparam logic [15:0] BCL_CRC_RESIDUE = 16'hf0b8;
  // ==========================================
  // Characters and error code
  localparam logic [7:0] BCL_CHR_PASS = 8'h59;
  localparam logic [7:0] BCL_CHR_FAIL = 8'h5a;
  localparam logic [7:0] BCL_CHR_CR = 8'h0d;
  localparam logic [7:0] BCL_CHR_LF = 8'h0a;
  localparam logic [7:0] BCL_ERR_CODE = 8'haa;
  // ==========================================
  // Timing
  localparam int unsigned BCL_CLK_KHZ = 125000;
  localparam int unsigned BCL_COPY_TIME_MS = 4000;
  localparam int unsigned BCL_COPY_CYC = BCL_COPY_TIME_MS * BCL_CLK_KHZ;
  // ==========================================
  // Types
  typedef enum logic [3:0] {
    BCL_S_IDLE = 4'b0000, BCL_S_ROM = 4'b0001, BCL_S_TWI = 4'b0010, BCL_S_UART = 4'b0011,
    BCL_S_PROG = 4'b0100, BCL_S_COPY = 4'b0101, BCL_S_CHECK = 4'b0110, BCL_S_REPORT = 4'b0111,
    BCL_S_ERR = 4'b1000, BCL_S_JUMP = 4'b1001, BCL_S_RUN = 4'b1010, BCL_S_HALT = 4'b1011
  } bcl_state_t;
  typedef enum logic [1:0] {
    BCL_SRC_NONE = 2'b00, BCL_SRC_TWI = 2'b01, BCL_SRC_UART = 2'b10, BCL_SRC_INT_EE = 2'b11
  } bcl_src_t;
  typedef enum logic [1:0] {
    BCL_CMD_NOP = 2'b00, BCL_CMD_ERASE = 2'b01, BCL_CMD_LVL1 = 2'b10, BCL_CMD_LVL2 = 2'b11
  } bcl_cmd_t;
  // Security level from the low two bits of a security byte
  function automatic logic [1:0] bcl_level(input logic [7:0] security_byte);
    bcl_level = !security_byte[1] ? 2'h2 : (!security_byte[0] ? 2'h1 : 2'h0);
  endfunction
  // One checksum byte step, reflected polynomial, right shifts
  function automatic logic [15:0] bcl_crc_step(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] w;
    w = {8'h00, data ^ crc[7:0]};
    for (int i = 0; i < 8; i++) begin
      w = w[0] ? ((w >> 1) ^ BCL_CRC_POLY) : (w >> 1);
    end
    bcl_crc_step = w ^ (crc >> 8);
  endfunction
endpackage

/* File: design/bcl_skid_buf.sv */
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes the same clock, synchronous active-low reset and clock enable as its parent.
*/
`timescale 1ns/1ns
module bcl_skid_buf import bcl_pkg::*; #(
  parameter int WIDTH = 22
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // ==========================================
  // Storage
  logic [WIDTH-1:0] mem_ff [2]; // Two words
  logic wr_ptr_ff; // Next slot to fill
  logic rd_ptr_ff; // Oldest slot
  logic [1:0] count_ff; // Words held
  logic push;
  logic pop;

  // Handshakes
  assign in_ready = (count_ff != 2'h2);
  assign out_valid = (count_ff != 2'h0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_ff[rd_ptr_ff];

  // Slot writes
  always_ff @(posedge sys_clk) begin
    if (clk_en && push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff <= 2'h0;
    end else if (clk_en) begin
      if (push) begin
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

/* File: design/bcl_loader.sv */
/*
  Boot code RAM loader: boot selection, memory map control, image load with checksum, security levels.
  Assumes one 125 MHz clock, byte sources and RAM writes on the same clock, port pins synchronised in two stages.
  // Function
  // RL1 - Boot select one runs customer ROM
  // RL2 - Map bit steers external moves to RAM
  // RL3 - Map bit overrides external RAM select
  // RL4 - Reset clears map bit
  // RL5 - Loader spans C000-FFFF, entry F800
  // RL6 - Program both memories, else copy EEPROM
  // RL7 - Good load jumps to zero
  // RL8 - Image keeps security and checksum on top
  // RL9 - Checksum accumulated, judged after full space
  // RL10 - Host link answers Y or Z
  // RL11 - Download failure sends AA, no start
  // RL12 - Checksum step uses reflected 8408 polynomial
  // RL13 - Start FFFF, accept residue F0B8
  // RL14 - Stored checksum low byte first
  // RL15 - Security byte decodes three levels
  // RL16 - Security level only rises
  // RL17 - Only full erase clears level two
  // RL18 - Code RAM copy level two blocks reads
  // RL19 - EEPROM level one blocks writes
  // RL20 - Bad EEPROM image never starts
  // RL21 - Probe two-wire bus before host link
  // RL22 - Allow four seconds for copy
  // RL23 - Security bit seven skips two-wire probe
  // RL24 - Security bit six skips host probe
  // RL25 - Low pins cancel the two skips
  // RL26 - One checksum step per write
*/
`timescale 1ns/1ns
module bcl_loader import bcl_pkg::*; #(
  parameter int unsigned COPY_CYC = BCL_COPY_CYC
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Boot configuration and register bus
  input wire logic [7:0] boot_hardware_config,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // External move routing
  input wire logic external_ram_select,
  input wire logic xmove_req,
  output logic xmove_to_code_ram,
  output logic xmove_to_expanded_data_ram,
  // Program counter control
  output logic run_rom,
  output logic pc_load,
  output logic [15:0] pc_value,
  // Source probing and pins
  input wire logic [7:0] ee_security_byte,
  output logic twi_probe_req,
  input wire logic twi_probe_done,
  input wire logic twi_slave_ack,
  input wire logic uart_rx_seen,
  input wire logic p35_pin,
  input wire logic p36_pin,
  output logic p37_out,
  output logic p37_oe,
  // Image byte stream
  output logic [1:0] load_src,
  input wire logic load_valid,
  output logic load_ready,
  input wire logic [7:0] load_data,
  // Code RAM and EEPROM write port
  output logic code_ram_wr_valid,
  input wire logic code_ram_wr_ready,
  output logic [13:0] code_ram_wr_addr,
  output logic [7:0] code_ram_wr_data,
  output logic ee_wr_en,
  // Host answer characters
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  // Programming commands and status
  input wire logic isp_cmd_valid,
  input wire logic [1:0] isp_cmd,
  output logic [1:0] ssb_level,
  output logic isp_read_ok,
  output logic isp_write_ok,
  output logic crc_pass,
  output logic crc_fail,
  output logic load_timeout
);
  // ==========================================
  // Declarations
  bcl_state_t state_ff, nxt_state; // Sequencer
  bcl_src_t src_ff; // Active image source
  logic map_bit_ff; // Code space map bit
  logic [1:0] pin_meta_ff, pin_sync_ff; // P3.5/P3.6 synchroniser
  logic [13:0] addr_ff; // Next byte address
  logic [15:0] crc_ff; // Running checksum
  logic last_in_ff; // Final byte accepted
  logic [7:0] code_ram_ssb_ff; // Security byte copy in code RAM
  logic [1:0] ee_level_ff; // EEPROM security level
  logic [1:0] tx_idx_ff; // Answer character index
  logic [7:0] err_sh_ff; // Error code shifter
  logic [3:0] err_cnt_ff; // Error bits left
  logic [31:0] copy_cnt_ff; // Copy time budget
  logic pass_ff, fail_ff, tout_ff; // Verdicts
  logic [15:0] pc_ff; // Jump target
  logic buf_in_valid, buf_in_ready, take;
  logic twi_probe_en, uart_probe_en;

  // ==========================================
  // Pin synchroniser, two stages
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_meta_ff <= 2'h3;
      pin_sync_ff <= 2'h3;
    end else if (clk_en) begin
      pin_meta_ff <= {p36_pin, p35_pin};
      pin_sync_ff <= pin_meta_ff;
    end
  end
  // RL23 RL24 RL25 probe enables
  assign twi_probe_en = ee_security_byte[BCL_SSB_TWI_EN_POS] || !pin_sync_ff[0];
  assign uart_probe_en = ee_security_byte[BCL_SSB_UART_EN_POS] || !pin_sync_ff[1];

  // ==========================================
  // Memory map control register
  always_ff @(posedge sys_clk) begin
    // RL4 reset clears map bit
    if (!rst_n) begin
      map_bit_ff <= BCL_MAP_BIT_RESET;
    end else if (clk_en && sfr_wr && sfr_addr == BCL_MAP_CTRL_ADDR) begin
      map_bit_ff <= sfr_wdata[BCL_MAP_BIT_POS];
    end
  end
  // Reserved bits read as zero
  assign sfr_rdata = (sfr_addr == BCL_MAP_CTRL_ADDR) ? {4'h0, map_bit_ff, 3'h0} : 8'h00;
  // RL2 RL3 map bit wins routing
  assign xmove_to_code_ram = xmove_req && map_bit_ff;
  assign xmove_to_expanded_data_ram = xmove_req && !map_bit_ff;

  // ==========================================
  // Sequencer next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      // RL1 boot select
      BCL_S_IDLE: nxt_state = boot_hardware_config[BCL_BOOT_SEL_POS] ? BCL_S_ROM : BCL_S_TWI;
      BCL_S_ROM: nxt_state = BCL_S_ROM;
      // RL21 two-wire first
      BCL_S_TWI: begin
        if (!twi_probe_en) begin
          nxt_state = BCL_S_UART;
        end else if (twi_probe_done) begin
          nxt_state = twi_slave_ack ? BCL_S_PROG : BCL_S_UART;
        end
      end
      BCL_S_UART: nxt_state = (uart_probe_en && uart_rx_seen) ? BCL_S_PROG : BCL_S_COPY;
      // RL19 locked EEPROM refuses programming
      BCL_S_PROG: begin
        if (!isp_write_ok) begin
          nxt_state = BCL_S_REPORT;
        end else if (last_in_ff) begin
          nxt_state = BCL_S_CHECK;
        end
      end
      // RL22 copy time budget
      BCL_S_COPY: begin
        if (last_in_ff) begin
          nxt_state = BCL_S_CHECK;
        end else if (copy_cnt_ff >= COPY_CYC) begin
          nxt_state = BCL_S_ERR;
        end
      end
      BCL_S_CHECK: begin
        if (!code_ram_wr_valid) begin
          nxt_state = (src_ff == BCL_SRC_UART) ? BCL_S_REPORT : (crc_ff == BCL_CRC_RESIDUE ? BCL_S_JUMP : BCL_S_ERR);
        end
      end
      BCL_S_REPORT: begin
        if (tx_ready && tx_idx_ff == 2'h2) begin
          nxt_state = pass_ff ? BCL_S_JUMP : BCL_S_HALT;
        end
      end
      BCL_S_ERR: nxt_state = (err_cnt_ff == 4'h1) ? BCL_S_HALT : BCL_S_ERR;
      BCL_S_JUMP: nxt_state = BCL_S_RUN;
      BCL_S_RUN: nxt_state = BCL_S_RUN;
      BCL_S_HALT: nxt_state = BCL_S_HALT;
      default: nxt_state = BCL_S_HALT;
    endcase
  end

  // Sequencer state and source
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_ff <= BCL_S_IDLE;
      src_ff <= BCL_SRC_NONE;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      // RL6 program from link or copy EEPROM
      if (state_ff == BCL_S_TWI && nxt_state == BCL_S_PROG) begin
        src_ff <= BCL_SRC_TWI;
      end else if (state_ff == BCL_S_UART) begin
        src_ff <= (nxt_state == BCL_S_PROG) ? BCL_SRC_UART : BCL_SRC_INT_EE;
      end
    end
  end

  // ==========================================
  // Program counter loads
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pc_load <= 1'b0;
      pc_ff <= BCL_APP_ENTRY;
    end else if (clk_en) begin
      pc_load <= 1'b0;
      // RL5 loader entry point
      if (state_ff == BCL_S_IDLE && !boot_hardware_config[BCL_BOOT_SEL_POS]) begin
        pc_load <= 1'b1;
        pc_ff <= BCL_LOADER_ENTRY;
      end
      // RL7 long jump to zero
      if (state_ff == BCL_S_JUMP) begin
        pc_load <= 1'b1;
        pc_ff <= BCL_APP_ENTRY;
      end
    end
  end
  assign pc_value = pc_ff;
  assign run_rom = (state_ff == BCL_S_ROM);
  assign twi_probe_req = (state_ff == BCL_S_TWI) && twi_probe_en;
  assign load_src = src_ff;
  assign ee_wr_en = (state_ff == BCL_S_PROG) || (state_ff == BCL_S_CHECK && src_ff != BCL_SRC_INT_EE);

  // ==========================================
  // Image intake and write buffer
  assign buf_in_valid = load_valid && (state_ff == BCL_S_PROG || state_ff == BCL_S_COPY) && !last_in_ff;
  assign load_ready = buf_in_ready && (state_ff == BCL_S_PROG || state_ff == BCL_S_COPY) && !last_in_ff && clk_en;
  assign take = buf_in_valid && buf_in_ready && (isp_write_ok || state_ff == BCL_S_COPY);

  bcl_skid_buf #(.WIDTH(22)) u_wbuf (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .in_valid(take),
    .in_ready(buf_in_ready),
    .in_data({addr_ff, load_data}),
    .out_valid(code_ram_wr_valid),
    .out_ready(code_ram_wr_ready),
    .out_data({code_ram_wr_addr, code_ram_wr_data})
  );

  // Address, checksum and security copy
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      addr_ff <= 14'h0000;
      crc_ff <= BCL_CRC_INIT;
      last_in_ff <= 1'b0;
      code_ram_ssb_ff <= 8'hff;
    end else if (clk_en && take) begin
      // RL26 RL12 one step per write
      crc_ff <= bcl_crc_step(crc_ff, load_data);
      addr_ff <= addr_ff + 14'h0001;
      // RL9 full space reached
      last_in_ff <= (addr_ff == BCL_LAST_ADDR);
      if (addr_ff == BCL_SSB_ADDR) begin
        code_ram_ssb_ff <= load_data;
      end
    end
  end

  // RL13 RL14 RL20 verdict on residue
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pass_ff <= 1'b0;
      fail_ff <= 1'b0;
    end else if (clk_en) begin
      if (state_ff == BCL_S_CHECK && !code_ram_wr_valid) begin
        pass_ff <= (crc_ff == BCL_CRC_RESIDUE);
        fail_ff <= (crc_ff != BCL_CRC_RESIDUE);
      end else if ((state_ff == BCL_S_PROG && !isp_write_ok) || (state_ff == BCL_S_COPY && nxt_state == BCL_S_ERR)) begin
        fail_ff <= 1'b1;
      end
    end
  end
  assign crc_pass = pass_ff;
  assign crc_fail = fail_ff;

  // RL22 copy time counter
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      copy_cnt_ff <= 32'h0;
      tout_ff <= 1'b0;
    end else if (clk_en && state_ff == BCL_S_COPY) begin
      copy_cnt_ff <= copy_cnt_ff + 32'h1;
      tout_ff <= tout_ff || (copy_cnt_ff >= COPY_CYC);
    end
  end
  assign load_timeout = tout_ff;

  // ==========================================
  // RL10 host answer characters
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_idx_ff <= 2'h0;
    end else if (clk_en && state_ff == BCL_S_REPORT && tx_ready) begin
      tx_idx_ff <= tx_idx_ff + 2'h1;
    end
  end
  assign tx_valid = (state_ff == BCL_S_REPORT);
  assign tx_data = (tx_idx_ff == 2'h0) ? (pass_ff ? BCL_CHR_PASS : BCL_CHR_FAIL) :
                   ((tx_idx_ff == 2'h1) ? BCL_CHR_CR : BCL_CHR_LF);

  // RL11 error code shifted out on P3.7
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      err_sh_ff <= BCL_ERR_CODE;
      err_cnt_ff <= 4'h8;
    end else if (clk_en && state_ff == BCL_S_ERR) begin
      err_sh_ff <= {err_sh_ff[6:0], 1'b1};
      err_cnt_ff <= err_cnt_ff - 4'h1;
    end
  end
  assign p37_out = (state_ff == BCL_S_ERR) ? err_sh_ff[7] : 1'b1;
  assign p37_oe = (state_ff == BCL_S_ERR);

  // ==========================================
  // Security level handling
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ee_level_ff <= 2'h2;
    end else if (clk_en) begin
      // RL15 decode at start
      if (state_ff == BCL_S_IDLE) begin
        ee_level_ff <= bcl_level(ee_security_byte);
      end else if (isp_cmd_valid) begin
        // RL17 erase alone clears
        if (isp_cmd == BCL_CMD_ERASE) begin
          ee_level_ff <= 2'h0;
        // RL16 only raise
        end else if (isp_cmd == BCL_CMD_LVL1 && ee_level_ff == 2'h0) begin
          ee_level_ff <= 2'h1;
        end else if (isp_cmd == BCL_CMD_LVL2) begin
          ee_level_ff <= 2'h2;
        end
      end
    end
  end
  assign ssb_level = ee_level_ff;
  // RL18 code RAM copy gates reads
  assign isp_read_ok = (bcl_level(code_ram_ssb_ff) != 2'h2);
  // RL19 EEPROM level gates writes
  assign isp_write_ok = (ee_level_ff == 2'h0);

  // ==========================================
  // Checks
  property p_boot_rom;
    @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && state_ff == BCL_S_IDLE && boot_hardware_config[BCL_BOOT_SEL_POS]) |=> run_rom;
  endproperty
  a_boot_rom: assert property (p_boot_rom) else $error("rom boot not taken"); // RL1
  property p_map_write;
    @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && sfr_wr && sfr_addr == BCL_MAP_CTRL_ADDR && sfr_wdata[BCL_MAP_BIT_POS]) ##1
      xmove_req |-> xmove_to_code_ram && !xmove_to_expanded_data_ram;
  endproperty
  a_map_write: assert property (p_map_write) else $error("map bit not steering"); // RL2
  property p_map_reset;
    @(posedge sys_clk) !rst_n |=> (sfr_rdata == 8'h00 || sfr_addr != BCL_MAP_CTRL_ADDR) && !xmove_to_code_ram;
  endproperty
  a_map_reset: assert property (p_map_reset) else $error("map bit not cleared"); // RL4
  property p_entry;
    @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && state_ff == BCL_S_IDLE && !boot_hardware_config[BCL_BOOT_SEL_POS]) |=>
      pc_load && pc_value == 16'hf800;
  endproperty
  a_entry: assert property (p_entry) else $error("loader entry wrong"); // RL5
  property p_jump;
    @(posedge sys_clk) disable iff (!rst_n)
      (pc_load && state_ff == BCL_S_RUN) |-> pc_value == 16'h0000 && crc_pass && !crc_fail;
  endproperty
  a_jump: assert property (p_jump) else $error("jump without pass"); // RL7
  property p_answer;
    @(posedge sys_clk) disable iff (!rst_n)
      (tx_valid && tx_idx_ff == 2'h0) |-> tx_data == (crc_pass ? 8'h59 : 8'h5a);
  endproperty
  a_answer: assert property (p_answer) else $error("wrong host answer"); // RL10
  property p_err_code;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(p37_oe) |-> p37_out ##1 !p37_out ##1 p37_out ##1 !p37_out;
  endproperty
  a_err_code: assert property (p_err_code) else $error("error code wrong"); // RL11
  property p_no_lower;
    @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && state_ff != BCL_S_IDLE && ssb_level == 2'h2 && isp_cmd_valid && isp_cmd == BCL_CMD_LVL1)
      |=> ssb_level == 2'h2;
  endproperty
  a_no_lower: assert property (p_no_lower) else $error("level lowered"); // RL16
  property p_halt_dead;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_ff == BCL_S_HALT) |-> !pc_load && !code_ram_wr_valid ##1 state_ff == BCL_S_HALT;
  endproperty
  a_halt_dead: assert property (p_halt_dead) else $error("failed image started"); // RL20
  c_rom: cover property (@(posedge sys_clk) disable iff (!rst_n) run_rom);
  c_run: cover property (@(posedge sys_clk) disable iff (!rst_n) state_ff == BCL_S_RUN);
  c_err: cover property (@(posedge sys_clk) disable iff (!rst_n) p37_oe);
  c_prog: cover property (@(posedge sys_clk) disable iff (!rst_n) state_ff == BCL_S_PROG && take);
endmodule

/* File: testbench/bcl_ee_model.sv */
/*
  Internal EEPROM image source and an empty two-wire bus for the loader.
  Assumes the loader's byte stream handshake on sys_clk.
*/
`timescale 1ns/1ns
module bcl_ee_model (
  // Clock, reset, fault select
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic corrupt,
  // Two-wire probe answer
  input wire logic twi_probe_req,
  output logic twi_probe_done,
  output logic twi_slave_ack,
  // Byte stream
  input wire logic load_ready,
  output logic load_valid,
  output logic [7:0] load_data
);
  // ==========================================
  // Image build
  logic [7:0] mem [16384];
  logic [14:0] idx_ff;
  logic [1:0] wait_ff;
  initial begin : build
    logic [15:0] crc;
    logic [15:0] w;
    crc = 16'hffff;
    for (int a = 0; a < 16382; a++) begin
      mem[a] = (a == 16381) ? 8'hff : 8'(a ^ (a >> 6));
      w = {8'h00, crc[7:0] ^ mem[a]};
      for (int b = 0; b < 8; b++) begin
        w = w[0] ? ((w >> 1) ^ 16'h8408) : (w >> 1);
      end
      crc = w ^ (crc >> 8);
    end
    mem[16382] = ~crc[7:0];
    mem[16383] = ~crc[15:8];
  end
  // Stream: one byte per handshake, junk when idle
  assign load_valid = !idx_ff[14];
  assign load_data = load_valid ? (mem[idx_ff[13:0]] ^ {7'h00, corrupt && idx_ff == 15'h5}) : ~idx_ff[7:0];
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      idx_ff <= 15'h0;
    end else if (load_valid && load_ready) begin
      idx_ff <= idx_ff + 15'h1;
    end
  end
  // No slave answers the probe
  assign twi_slave_ack = 1'b0;
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !twi_probe_req) begin
      wait_ff <= 2'h0;
    end else if (wait_ff != 2'h3) begin
      wait_ff <= wait_ff + 2'h1;
    end
    twi_probe_done <= rst_n && twi_probe_req && wait_ff == 2'h2;
  end
endmodule

/* File: testbench/tb_top.sv */
/*
  Bench for the loader: map register, image copy, bad image, security, ROM boot.
  Assumes the EEPROM model on the stream and a code RAM that stalls.
*/
`timescale 1ns/1ns
module tb_top import bcl_pkg::*;;
  // ==========================================
  // Signals
  logic sys_clk, rst_n, clk_en, sfr_wr, external_ram_select, xmove_req, twi_probe_req, twi_probe_done;
  logic twi_slave_ack, uart_rx_seen, p35_pin, p36_pin, p37_out, p37_oe, load_valid, load_ready;
  logic code_ram_wr_valid, code_ram_wr_ready, ee_wr_en, tx_valid, tx_ready, isp_cmd_valid, isp_read_ok;
  logic isp_write_ok, crc_pass, crc_fail, load_timeout, run_rom, pc_load, corrupt, app_jump;
  logic xmove_to_code_ram, xmove_to_expanded_data_ram, src_copy, twi_seen;
  logic [1:0] load_src, isp_cmd, ssb_level;
  logic [7:0] boot_hardware_config, sfr_addr, sfr_wdata, sfr_rdata, ee_security_byte, load_data, code_ram_wr_data;
  logic [7:0] tx_data, aa_sh;
  logic [23:0] tx_sh;
  logic [13:0] code_ram_wr_addr;
  logic [15:0] pc_value, last_pc;
  int num_errors, checks_done, wr_cnt, order_err, refused, aa_n, pc_cnt, cyc;
  wire [2:0] ev = {app_jump, aa_n >= 8, crc_pass | crc_fail};
  bcl_loader #(.COPY_CYC(40000)) bcl_loader_i (.sys_clk, .rst_n, .clk_en, .boot_hardware_config, .sfr_addr,
    .sfr_wr, .sfr_wdata, .sfr_rdata, .external_ram_select, .xmove_req, .xmove_to_code_ram, .xmove_to_expanded_data_ram,
    .run_rom, .pc_load, .pc_value, .ee_security_byte, .twi_probe_req, .twi_probe_done, .twi_slave_ack,
    .uart_rx_seen, .p35_pin, .p36_pin, .p37_out, .p37_oe, .load_src, .load_valid, .load_ready, .load_data,
    .code_ram_wr_valid, .code_ram_wr_ready, .code_ram_wr_addr, .code_ram_wr_data, .ee_wr_en, .tx_valid, .tx_ready, .tx_data,
    .isp_cmd_valid, .isp_cmd, .ssb_level, .isp_read_ok, .isp_write_ok, .crc_pass, .crc_fail, .load_timeout);
  bcl_ee_model bcl_ee_model_i (.sys_clk, .rst_n, .corrupt, .twi_probe_req, .twi_probe_done, .twi_slave_ack,
    .load_ready, .load_valid, .load_data);
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Code RAM stalls 8 of every 256 cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    code_ram_wr_ready <= cyc[7:3] != 5'h0;
  end
  // ==========================================
  // Monitor
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_cnt <= 0;
      order_err <= 0;
      refused <= 0;
      aa_n <= 0;
      pc_cnt <= 0;
      app_jump <= 1'b0;
      twi_seen <= 1'b0;
      src_copy <= 1'b0;
    end else begin
      if (code_ram_wr_valid && code_ram_wr_ready) begin
        wr_cnt <= wr_cnt + 1;
        order_err <= order_err + int'(code_ram_wr_addr !== wr_cnt[13:0]);
      end
      refused <= refused + int'(load_valid && !load_ready && load_src === BCL_SRC_INT_EE);
      if (p37_oe) begin
        aa_sh <= {aa_sh[6:0], p37_out};
        aa_n <= aa_n + 1;
      end
      if (pc_load) begin
        last_pc <= pc_value;
        pc_cnt <= pc_cnt + 1;
        app_jump <= pc_value === BCL_APP_ENTRY;
      end
      if (tx_valid && tx_ready) begin
        tx_sh <= {tx_sh[15:0], tx_data};
      end
      twi_seen <= twi_seen | twi_probe_req;
      src_copy <= src_copy | (twi_seen && load_src === BCL_SRC_INT_EE);
    end
  end
  // ==========================================
  // Shared tasks
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wait_ev(input int k, input int n);
    int i;
    i = 0;
    while (ev[k] !== 1'b1 && i < n) begin
      @(posedge sys_clk);
      #1;
      i++;
    end
    if (ev[k] !== 1'b1) begin
      chk("wait event", 16'h1, 16'h0);
      report_and_stop();
    end
  endtask
  task automatic do_reset(input logic [7:0] cfg, input logic bad);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    boot_hardware_config <= cfg;
    corrupt <= bad;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask
  task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic in_system_programming(input logic [1:0] c, input logic [1:0] e);
    @(posedge sys_clk);
    isp_cmd_valid <= 1'b1;
    isp_cmd <= c;
    @(posedge sys_clk);
    isp_cmd_valid <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("security level", 16'(e), 16'(ssb_level));
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regs();
    repeat (4) @(posedge sys_clk);
    #1;
    chk("loader entry", BCL_LOADER_ENTRY, last_pc);
    chk("map after reset", 16'h0, 16'(sfr_rdata));
    sfr_w(8'hd1, 8'hff);
    chk("map set", 16'h8, 16'(sfr_rdata));
    chk("move to code ram", 16'h1, 16'(xmove_to_code_ram));
    chk("move to data ram", 16'h0, 16'(xmove_to_expanded_data_ram));
    sfr_w(8'h55, 8'hff);
    chk("unmapped read", 16'h0, 16'(sfr_rdata));
    sfr_w(8'hd1, 8'h00);
    chk("move to data ram", 16'h1, 16'(xmove_to_expanded_data_ram));
  endtask
  task automatic t_copy_ok();
    wait_ev(0, 40000);
    chk("checksum pass", 16'h1, 16'(crc_pass));
    chk("bytes written", 16'h4000, wr_cnt[15:0]);
    chk("address order", 16'h0, order_err[15:0]);
    chk("stall refused", 16'h1, 16'(refused > 0));
    chk("probe before copy", 16'h1, 16'(src_copy));
    wait_ev(2, 100);
    chk("application entry", BCL_APP_ENTRY, last_pc);
  endtask
  task automatic t_security();
    in_system_programming(BCL_CMD_ERASE, 2'h0);
    in_system_programming(BCL_CMD_LVL1, 2'h1);
    chk("write allowed", 16'h0, 16'(isp_write_ok));
    in_system_programming(BCL_CMD_LVL2, 2'h2);
    in_system_programming(BCL_CMD_LVL1, 2'h2);
    in_system_programming(BCL_CMD_ERASE, 2'h0);
    chk("write allowed", 16'h1, 16'(isp_write_ok));
  endtask
  task automatic t_copy_bad();
    do_reset(8'h00, 1'b1);
    wait_ev(0, 40000);
    chk("checksum fail", 16'h1, 16'(crc_fail));
    wait_ev(1, 200);
    chk("error code", 16'(BCL_ERR_CODE), 16'(aa_sh));
    repeat (50) @(posedge sys_clk);
    #1;
    chk("jumps taken", 16'h1, pc_cnt[15:0]);
  endtask
  task automatic t_host();
    do_reset(8'h00, 1'b0);
    uart_rx_seen <= 1'b1;
    wait_ev(2, 40000);
    chk("host source", 16'(BCL_SRC_UART), 16'(load_src));
    chk("host answer", {BCL_CHR_PASS, BCL_CHR_CR}, tx_sh[23:8]);
  endtask
  task automatic t_rom();
    do_reset(8'h40, 1'b0);
    repeat (4) @(posedge sys_clk);
    #1;
    chk("rom run", 16'h1, 16'(run_rom));
    chk("load source", 16'h0, 16'(load_src));
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {rst_n, sfr_wr, isp_cmd_valid, corrupt, uart_rx_seen, isp_cmd, cyc} = '0;
    {clk_en, p35_pin, p36_pin, tx_ready, xmove_req, external_ram_select} = 6'h3f;
    {num_errors, checks_done, code_ram_wr_ready} = '0;
    {boot_hardware_config, sfr_wdata} = '0;
    sfr_addr = 8'hd1;
    ee_security_byte = 8'hff;
    do_reset(8'h00, 1'b0);
    t_regs();
    t_copy_ok();
    t_security();
    t_copy_bad();
    t_host();
    t_rom();
    report_and_stop();
  end
endmodule
